// ===== cal_channel_core.sv
// per-channel offset, linear scaling, alarm latching and apb registers
`timescale 1ns/100ps
module cal_channel_core #(
	parameter int unsigned NCH = 8
) (
	input  wire logic                              clk_in,
	input  wire logic                              rst_in,
	// apb slave
	input  wire logic                              psel_in,
	input  wire logic                              penable_in,
	input  wire logic                              pwrite_in,
	input  wire logic [cal_pkg::CAL_ADDR_W-1:0]    paddr_in,
	input  wire logic [cal_pkg::CAL_DATA_W-1:0]    pwdata_in,
	output logic      [cal_pkg::CAL_DATA_W-1:0]    prdata_out,
	output logic                                   pready_out,
	output logic                                   pslverr_out,
	// raw samples, q16.16 signal units
	input  wire logic                              raw_valid_in,
	input  wire logic [$clog2(NCH)-1:0]            raw_chan_in,
	input  wire logic [31:0]                       raw_value_in,
	output logic                                   raw_ready_out,
	// alarm levels and interrupt
	output logic      [NCH*cal_pkg::CAL_ALM_W-1:0] alarm_out,
	output logic                                   irq_out
);
	import cal_pkg::*;

	localparam int unsigned CH_W = $clog2(NCH);

	// configuration per channel
	logic [31:0]          lo_sig_reg  [NCH];
	logic [31:0]          hi_sig_reg  [NCH];
	logic [31:0]          lo_eng_reg  [NCH];
	logic [31:0]          hi_eng_reg  [NCH];
	logic [31:0]          offset_reg  [NCH];
	logic [31:0]          lo_lim_reg  [NCH];
	logic [31:0]          hi_lim_reg  [NCH];
	logic [31:0]          rate_reg    [NCH];
	logic [CAL_CTL_W-1:0] ctrl_reg    [NCH];
	// results per channel
	logic [CAL_ALM_W-1:0] alarm_reg   [NCH];
	logic [31:0]          data_reg    [NCH];
	logic [31:0]          prev_reg    [NCH];
	logic [NCH-1:0]       has_prev_reg;
	logic [NCH-1:0]       irq_stat_reg;
	logic [NCH-1:0]       irq_mask_reg;

	// engine
	cal_state_e           state_reg;
	logic [CH_W-1:0]      cur_ch_reg;
	logic [31:0]          cur_lo_eng_reg;

	// apb decode
	logic [11:0]          ch_rel;
	logic [5:0]           fld;
	logic [5:0]           ch_num;
	logic [CH_W-1:0]      ch_sel;
	logic                 in_chan;
	logic                 is_stat;
	logic                 is_mask;
	logic                 fld_ok;
	logic                 mapped;
	logic                 setup;
	logic                 wr_en;
	logic                 ch_wr;
	logic [31:0]          rd_word;
	logic [31:0]          ch_word;

	assign ch_rel  = paddr_in - CAL_CH_BASE;
	assign fld     = ch_rel[CAL_CH_SHIFT-1:0];
	assign ch_num  = ch_rel[11:CAL_CH_SHIFT];
	assign ch_sel  = ch_num[CH_W-1:0];
	assign in_chan = (paddr_in >= CAL_CH_BASE) && (ch_num < 6'(NCH));
	assign is_stat = paddr_in == CAL_OFF_IRQ_STATUS;
	assign is_mask = paddr_in == CAL_OFF_IRQ_MASK;
	assign fld_ok  = (fld[1:0] == 2'b00) && (fld <= CAL_FLD_DATA);
	assign mapped  = is_stat || is_mask || (in_chan && fld_ok);
	assign setup   = psel_in && !penable_in;
	assign wr_en   = psel_in && penable_in && pwrite_in && mapped;
	assign ch_wr   = wr_en && in_chan;

	// zero wait state: every access phase completes at once
	assign pready_out = 1'b1;

	// channel field read selection; unlatch reads as zero
	assign ch_word =
		(fld == CAL_FLD_LO_SIG)  ? lo_sig_reg[ch_sel] :
		(fld == CAL_FLD_HI_SIG)  ? hi_sig_reg[ch_sel] :
		(fld == CAL_FLD_LO_ENG)  ? lo_eng_reg[ch_sel] :
		(fld == CAL_FLD_HI_ENG)  ? hi_eng_reg[ch_sel] :
		(fld == CAL_FLD_OFFSET)  ? offset_reg[ch_sel] :
		(fld == CAL_FLD_LO_LIM)  ? lo_lim_reg[ch_sel] :
		(fld == CAL_FLD_HI_LIM)  ? hi_lim_reg[ch_sel] :
		(fld == CAL_FLD_RATE)    ? rate_reg[ch_sel] :
		(fld == CAL_FLD_CTRL)    ? 32'(ctrl_reg[ch_sel]) :
		(fld == CAL_FLD_ALARM)   ? 32'(alarm_reg[ch_sel]) :
		(fld == CAL_FLD_DATA)    ? data_reg[ch_sel] :
		CAL_RST_ZERO;

	assign rd_word = is_stat ? 32'(irq_stat_reg) :
		is_mask ? 32'(irq_mask_reg) :
		(in_chan && fld_ok) ? ch_word : CAL_RST_ZERO;

	// read data and error captured in the setup cycle
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out  <= CAL_RST_ZERO;
			pslverr_out <= 1'b0;
		end else if (setup) begin
			prdata_out  <= pwrite_in ? CAL_RST_ZERO : rd_word;
			pslverr_out <= !mapped;
		end
	end

	// configuration writes
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NCH; i++) begin
				lo_sig_reg[i] <= CAL_RST_ZERO;
				hi_sig_reg[i] <= CAL_RST_ONE;
				lo_eng_reg[i] <= CAL_RST_ZERO;
				hi_eng_reg[i] <= CAL_RST_ONE;
				offset_reg[i] <= CAL_RST_ZERO;
				lo_lim_reg[i] <= CAL_RST_LO_LIM;
				hi_lim_reg[i] <= CAL_RST_HI_LIM;
				rate_reg[i]   <= CAL_RST_RATE;
				ctrl_reg[i]   <= '0;
			end
		end else if (ch_wr) begin
			unique case (fld)
				CAL_FLD_LO_SIG: lo_sig_reg[ch_sel] <= pwdata_in;
				CAL_FLD_HI_SIG: hi_sig_reg[ch_sel] <= pwdata_in;
				CAL_FLD_LO_ENG: lo_eng_reg[ch_sel] <= pwdata_in;
				CAL_FLD_HI_ENG: hi_eng_reg[ch_sel] <= pwdata_in;
				CAL_FLD_OFFSET: offset_reg[ch_sel] <= pwdata_in;
				CAL_FLD_LO_LIM: lo_lim_reg[ch_sel] <= pwdata_in;
				CAL_FLD_HI_LIM: hi_lim_reg[ch_sel] <= pwdata_in;
				CAL_FLD_RATE:   rate_reg[ch_sel]   <= pwdata_in;
				CAL_FLD_CTRL:   ctrl_reg[ch_sel]   <= pwdata_in[CAL_CTL_W-1:0];
				default:        ;
			endcase
		end
	end

	// sample arithmetic: offset first, then the scaling numerator
	logic signed [31:0] x_corr;
	logic signed [31:0] x_rel;
	logic signed [31:0] span_eng;
	logic signed [31:0] span_sig;
	logic signed [63:0] numer;
	logic               start;
	logic               div_done;
	logic        [31:0] quot;

	assign x_corr   = raw_value_in + offset_reg[raw_chan_in];
	assign x_rel    = x_corr - lo_sig_reg[raw_chan_in];
	assign span_eng = hi_eng_reg[raw_chan_in] - lo_eng_reg[raw_chan_in];
	assign span_sig = hi_sig_reg[raw_chan_in] - lo_sig_reg[raw_chan_in];
	assign numer    = x_rel * span_eng;
	assign raw_ready_out = state_reg == CAL_ST_IDLE;
	assign start    = raw_valid_in && raw_ready_out;

	// q32.32 over q16.16 leaves the q16.16 slope term
	cal_divider #(
		.NUM_W (64),
		.DEN_W (32)
	) u_div (
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.start_in (start),
		.num_in   (numer),
		.den_in   (span_sig),
		.done_out (div_done),
		.quot_out (quot)
	);

	// engine state and captured channel context
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			state_reg      <= CAL_ST_IDLE;
			cur_ch_reg     <= '0;
			cur_lo_eng_reg <= CAL_RST_ZERO;
		end else begin
			unique case (state_reg)
				CAL_ST_IDLE: begin
					if (start) begin
						state_reg      <= CAL_ST_CALC;
						cur_ch_reg     <= raw_chan_in;
						cur_lo_eng_reg <= lo_eng_reg[raw_chan_in];
					end
				end
				CAL_ST_CALC: begin
					if (div_done)
						state_reg <= CAL_ST_IDLE;
				end
			endcase
		end
	end

	// scaled value, no clipping of the engineering range
	logic signed [31:0] eng;
	logic signed [31:0] lo_lim;
	logic signed [31:0] hi_lim;
	logic signed [32:0] delta;
	logic        [32:0] delta_mag;
	logic               out_mode;
	logic               cond_ll;
	logic               cond_hh;
	logic               cond_rate;
	logic        [31:0] eng_out;
	logic [CAL_ALM_W-1:0] cond;

	assign eng       = cur_lo_eng_reg + quot;
	assign lo_lim    = lo_lim_reg[cur_ch_reg];
	assign hi_lim    = hi_lim_reg[cur_ch_reg];
	assign out_mode  = ctrl_reg[cur_ch_reg][CAL_CTL_OUTPUT];
	assign cond_ll   = eng < lo_lim;
	assign cond_hh   = eng > hi_lim;
	assign delta     = 33'(eng) - 33'($signed(prev_reg[cur_ch_reg]));
	assign delta_mag = delta[32] ? 33'(-delta) : delta;
	assign cond_rate = has_prev_reg[cur_ch_reg] &&
		(delta_mag > {1'b0, rate_reg[cur_ch_reg]});
	assign cond      = {cond_rate, cond_hh, cond_ll};

	// output channels clamp to the limits; inputs pass through
	assign eng_out = (out_mode && cond_ll) ? lo_lim :
		(out_mode && cond_hh) ? hi_lim : eng;

	// q16.16 to ieee single, truncating extra low bits
	function automatic logic [31:0] fix_to_float(input logic [31:0] v);
		logic [31:0] mag;
		logic [31:0] norm;
		logic [4:0]  msb;
		mag  = v[31] ? 32'(-v) : v;
		msb  = '0;
		for (int i = 0; i < 32; i++) begin
			if (mag[i])
				msb = 5'(i);
		end
		norm = mag << (5'd31 - msb);
		if (mag == '0)
			fix_to_float = CAL_RST_ZERO;
		else
			fix_to_float = {v[31],
				8'(32'(msb) + CAL_FLT_BIAS - CAL_FRAC_BITS), norm[30:8]};
	endfunction

	// unlatch requests, one bit per alarm kind
	logic                 unl_wr;
	logic [CAL_ALM_W-1:0] unl_bits;

	assign unl_wr   = ch_wr && (fld == CAL_FLD_UNLATCH);
	assign unl_bits = pwdata_in[CAL_ALM_W-1:0];

	// alarm latching and channel data update
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			for (int i = 0; i < NCH; i++) begin
				alarm_reg[i] <= '0;
				data_reg[i]  <= CAL_RST_ZERO;
				prev_reg[i]  <= CAL_RST_ZERO;
			end
			has_prev_reg <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (ctrl_reg[i][CAL_CTL_LATCH]) begin
					// clear only by request; fresh set wins
					if (unl_wr && ch_sel == CH_W'(i))
						alarm_reg[i] <= alarm_reg[i] & ~unl_bits;
					if (div_done && cur_ch_reg == CH_W'(i))
						alarm_reg[i] <= (unl_wr && ch_sel == CH_W'(i) ?
							alarm_reg[i] & ~unl_bits : alarm_reg[i])
							| cond;
				end else if (div_done && cur_ch_reg == CH_W'(i)) begin
					alarm_reg[i] <= cond;               // follows the condition
				end
			end
			if (div_done) begin
				data_reg[cur_ch_reg] <= fix_to_float(eng_out);
				prev_reg[cur_ch_reg]     <= eng;
				has_prev_reg[cur_ch_reg] <= 1'b1;
			end
		end
	end

	// alarm rising edges feed the interrupt status
	logic [NCH-1:0] irq_set;
	logic [NCH-1:0] irq_clr;

	always_comb begin
		irq_set = '0;
		for (int i = 0; i < NCH; i++) begin
			if (div_done && cur_ch_reg == CH_W'(i))
				irq_set[i] = |(cond & ~alarm_reg[i]);
		end
	end
	assign irq_clr = (wr_en && is_stat) ? pwdata_in[NCH-1:0] : '0;

	// sticky status, write one to clear, set wins
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			irq_stat_reg <= '0;
			irq_mask_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
			if (wr_en && is_mask)
				irq_mask_reg <= pwdata_in[NCH-1:0];
		end
	end

	assign irq_out = |(irq_stat_reg & irq_mask_reg);

	// flatten alarm levels for the pins
	always_comb begin
		alarm_out = '0;
		for (int i = 0; i < NCH; i++)
			alarm_out[i*CAL_ALM_W +: CAL_ALM_W] = alarm_reg[i];
	end

endmodule

// ===== cal_channel_core_asserts.sv
// port-level assertions for the channel alarm latch and scaling core
`timescale 1ns/100ps
module cal_channel_core_asserts
	import cal_pkg::*;
#(
	parameter int unsigned NCH = 8
) (
	input wire logic                     clk_in,
	input wire logic                     rst_in,
	input wire logic                     psel_in,
	input wire logic                     penable_in,
	input wire logic                     pwrite_in,
	input wire logic [CAL_ADDR_W-1:0]    paddr_in,
	input wire logic [CAL_DATA_W-1:0]    pwdata_in,
	input wire logic [CAL_DATA_W-1:0]    prdata_out,
	input wire logic                     pready_out,
	input wire logic                     pslverr_out,
	input wire logic                     raw_valid_in,
	input wire logic [$clog2(NCH)-1:0]   raw_chan_in,
	input wire logic [31:0]              raw_value_in,
	input wire logic                     raw_ready_out,
	input wire logic [NCH*CAL_ALM_W-1:0] alarm_out,
	input wire logic                     irq_out
);
	// access phase, write commit, address decode and sample take
	wire acc  = psel_in && penable_in;
	wire wr   = acc && pwrite_in;
	wire chw  = paddr_in >= 12'h100 && paddr_in < 12'h100 + NCH * 64;
	wire fok  = paddr_in[5:0] <= 6'h2C && paddr_in[1:0] == 2'h0;
	wire map  = paddr_in == 12'h000 || paddr_in == 12'h004 || (chw && fok);
	wire take = raw_valid_in && raw_ready_out;

	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);

	a_ready_always: assert property (pready_out)
		else $error("pready low");
	a_unmapped_err: assert property (acc |-> pslverr_out == !map)
		else $error("slave error decode wrong");
	a_unlatch_zero: assert property (acc && !pwrite_in && chw && paddr_in[5:0] == 6'h24 |-> prdata_out == 32'h0000_0000)
		else $error("unlatch field read not zero");
	a_rdata_stands: assert property (!(psel_in && !penable_in) |=> $stable(prdata_out))
		else $error("read data moved outside setup");
	a_busy_window: assert property (take |=> !raw_ready_out ##64 !raw_ready_out ##1 raw_ready_out)
		else $error("engine busy window wrong");
	a_alarm_rise: assert property (|(alarm_out & ~$past(alarm_out)) |-> !$past(raw_ready_out))
		else $error("alarm set outside evaluation");
	a_alarm_fall: assert property (|(~alarm_out & $past(alarm_out)) |-> !$past(raw_ready_out) || $past(wr))
		else $error("alarm cleared without cause");
	a_irq_rise: assert property ($rose(irq_out) |-> !$past(raw_ready_out) || $past(wr))
		else $error("interrupt rose without cause");
	a_irq_fall: assert property ($fell(irq_out) |-> $past(wr))
		else $error("interrupt fell without write");
endmodule

// ===== cal_divider.sv
// signed restoring divider, one quotient bit per clock
`timescale 1ns/100ps
module cal_divider #(
	parameter int unsigned NUM_W = 64,
	parameter int unsigned DEN_W = 32
) (
	input  wire logic                    clk_in,
	input  wire logic                    rst_in,
	input  wire logic                    start_in,
	input  wire logic signed [NUM_W-1:0] num_in,
	input  wire logic signed [DEN_W-1:0] den_in,
	output logic                         done_out,
	output logic             [DEN_W-1:0] quot_out
);
	localparam int unsigned CNT_W = $clog2(NUM_W + 1);

	logic [NUM_W-1:0] quo_reg;
	logic [DEN_W:0]   rem_reg;
	logic [DEN_W:0]   den_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic             busy_reg;
	logic             neg_reg;
	logic             zero_reg;
	logic [DEN_W:0]   rem_shift;
	logic             fits;
	logic [NUM_W-1:0] quo_step;
	logic [DEN_W:0]   rem_step;
	logic [NUM_W-1:0] num_mag;
	logic [DEN_W-1:0] den_mag;
	logic [DEN_W-1:0] quo_low;
	logic             last_step;

	// magnitudes of the operands, sign kept apart
	assign num_mag   = num_in[NUM_W-1] ? NUM_W'(-num_in) : num_in;
	assign den_mag   = den_in[DEN_W-1] ? DEN_W'(-den_in) : den_in;

	// one restoring step
	assign rem_shift = {rem_reg[DEN_W-1:0], quo_reg[NUM_W-1]};
	assign fits      = rem_shift >= den_reg;
	assign rem_step  = fits ? rem_shift - den_reg : rem_shift;
	assign quo_step  = {quo_reg[NUM_W-2:0], fits};
	assign quo_low   = quo_step[DEN_W-1:0];
	assign last_step = busy_reg && (cnt_reg == CNT_W'(NUM_W - 1));

	// iteration state; a zero divisor yields a zero quotient
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			quo_reg  <= '0;
			rem_reg  <= '0;
			den_reg  <= '0;
			cnt_reg  <= '0;
			busy_reg <= 1'b0;
			neg_reg  <= 1'b0;
			zero_reg <= 1'b0;
		end else if (start_in && !busy_reg) begin
			quo_reg  <= num_mag;
			rem_reg  <= '0;
			den_reg  <= {1'b0, den_mag};
			cnt_reg  <= '0;
			busy_reg <= 1'b1;
			neg_reg  <= num_in[NUM_W-1] ^ den_in[DEN_W-1];
			zero_reg <= den_mag == '0;
		end else if (busy_reg) begin
			quo_reg  <= quo_step;
			rem_reg  <= rem_step;
			cnt_reg  <= cnt_reg + 1'b1;
			busy_reg <= !last_step;
		end
	end

	// result register and one-cycle done pulse
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			quot_out <= '0;
			done_out <= 1'b0;
		end else begin
			done_out <= last_step;
			if (last_step) begin
				if (zero_reg)
					quot_out <= '0;
				else
					quot_out <= neg_reg ? DEN_W'(-quo_low) : quo_low;
			end
		end
	end

endmodule

// ===== cal_pkg.sv
// constants shared by the channel alarm latch and scaling block
package cal_pkg;

	// apb address width and word layout
	localparam int unsigned CAL_ADDR_W      = 12;
	localparam int unsigned CAL_DATA_W      = 32;

	// global registers
	localparam logic [11:0] CAL_OFF_IRQ_STATUS = 12'h000;
	localparam logic [11:0] CAL_OFF_IRQ_MASK   = 12'h004;

	// channel window: base plus channel number times stride
	localparam logic [11:0] CAL_CH_BASE     = 12'h100;
	localparam int unsigned CAL_CH_SHIFT    = 6;

	// field offsets inside one channel window
	localparam logic [5:0]  CAL_FLD_LO_SIG  = 6'h00;
	localparam logic [5:0]  CAL_FLD_HI_SIG  = 6'h04;
	localparam logic [5:0]  CAL_FLD_LO_ENG  = 6'h08;
	localparam logic [5:0]  CAL_FLD_HI_ENG  = 6'h0C;
	localparam logic [5:0]  CAL_FLD_OFFSET  = 6'h10;
	localparam logic [5:0]  CAL_FLD_LO_LIM  = 6'h14;
	localparam logic [5:0]  CAL_FLD_HI_LIM  = 6'h18;
	localparam logic [5:0]  CAL_FLD_RATE    = 6'h1C;
	localparam logic [5:0]  CAL_FLD_CTRL    = 6'h20;
	localparam logic [5:0]  CAL_FLD_UNLATCH = 6'h24;
	localparam logic [5:0]  CAL_FLD_ALARM   = 6'h28;
	localparam logic [5:0]  CAL_FLD_DATA    = 6'h2C;

	// control field bit positions
	localparam int unsigned CAL_CTL_LATCH   = 0;
	localparam int unsigned CAL_CTL_OUTPUT  = 1;
	localparam int unsigned CAL_CTL_W       = 2;

	// alarm and unlatch bit positions
	localparam int unsigned CAL_ALM_LOW_LOW = 0;
	localparam int unsigned CAL_ALM_HI_HI   = 1;
	localparam int unsigned CAL_ALM_RATE    = 2;
	localparam int unsigned CAL_ALM_W       = 3;

	// reset values, fixed point q16.16
	localparam logic [31:0] CAL_RST_ZERO    = 32'h0000_0000;
	localparam logic [31:0] CAL_RST_ONE     = 32'h0001_0000;
	localparam logic [31:0] CAL_RST_LO_LIM  = 32'h8000_0000;
	localparam logic [31:0] CAL_RST_HI_LIM  = 32'h7FFF_FFFF;
	localparam logic [31:0] CAL_RST_RATE    = 32'h7FFF_FFFF;

	// float conversion: fraction bits and exponent bias
	localparam int unsigned CAL_FRAC_BITS   = 16;
	localparam int unsigned CAL_FLT_BIAS    = 127;

	// engine states
	typedef enum logic [1:0] {
		CAL_ST_IDLE = 2'b01,
		CAL_ST_CALC = 2'b10
	} cal_state_e;

endpackage

// ===== cal_sample_src.sv
// raw sample source standing in for the analog front end
`timescale 1ns/100ps
module cal_sample_src #(
	parameter int unsigned CW = 2
) (
	input  wire logic     clk_in,
	input  wire logic     raw_ready_in,
	output logic          raw_valid_out,
	output logic [CW-1:0] raw_chan_out,
	output logic [31:0]   raw_value_out
);
	// idle lines at time zero
	initial begin
		raw_valid_out = 1'b0;
		raw_chan_out  = '0;
		raw_value_out = 32'h0000_0000;
	end

	// offer one sample, hold until taken, then wait for the result
	task automatic send(input int ch, input logic [31:0] v);
		while (raw_ready_in !== 1'b1) @(negedge clk_in);
		@(posedge clk_in);
		raw_valid_out <= 1'b1;
		raw_chan_out  <= CW'(ch);
		raw_value_out <= v;
		do @(posedge clk_in); while (raw_ready_in !== 1'b1);
		raw_valid_out <= 1'b0;
		raw_value_out <= ~v; // stale value must not look valid
		repeat (2) @(negedge clk_in);
		while (raw_ready_in !== 1'b1) @(negedge clk_in);
	endtask
endmodule

// ===== test_channel_alarm_latch_and_scaling.sv
// self-checking bench for the channel alarm latch and scaling core
`timescale 1ns/100ps
module test_channel_alarm_latch_and_scaling;
	import cal_pkg::*;
	localparam int unsigned NCH = 4;
	logic                     clk_in, rst_in, psel_in, penable_in, pwrite_in;
	logic [11:0]              paddr_in;
	logic [31:0]              pwdata_in, prdata_out, rd, raw_value_in;
	logic                     pready_out, pslverr_out, err, irq_out;
	logic                     raw_valid_in, raw_ready_out;
	logic [1:0]               raw_chan_in;
	logic [NCH*CAL_ALM_W-1:0] alarm_out;
	int                       n_errors, samples_checked, cycles;

	cal_channel_core #(.NCH(NCH)) i_dut (.clk_in(clk_in), .rst_in(rst_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.raw_valid_in(raw_valid_in), .raw_chan_in(raw_chan_in),
		.raw_value_in(raw_value_in), .raw_ready_out(raw_ready_out),
		.alarm_out(alarm_out), .irq_out(irq_out));
	cal_sample_src i_src (.clk_in(clk_in), .raw_ready_in(raw_ready_out),
		.raw_valid_out(raw_valid_in), .raw_chan_out(raw_chan_in),
		.raw_value_out(raw_value_in));

	// clock and hang guard
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			n_errors++;
			end_of_test();
		end
	end

	task automatic end_of_test;
		if (n_errors == 0 && samples_checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= w;
		paddr_in   <= a;
		pwdata_in  <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do @(posedge clk_in); while (pready_out !== 1'b1);
		rd = prdata_out;
		err = pslverr_out;
		psel_in    <= 1'b0;
		penable_in <= 1'b0;
		@(negedge clk_in);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, exp);
	endtask

	function automatic logic [11:0] ca(input int c, input logic [5:0] f);
		return CAL_CH_BASE + 12'(c * 64) + 12'(f);
	endfunction

	function automatic logic [31:0] alm(input int c);
		return {29'h0, alarm_out[3*c +: 3]};
	endfunction

	// reset values, unmapped access, write-only unlatch field
	task automatic t_regs;
		rdchk(ca(0, CAL_FLD_HI_SIG), CAL_RST_ONE);
		rdchk(ca(1, CAL_FLD_CTRL), 32'h0000_0000);
		apb(1'b0, 12'h008, 32'h0000_0000);
		chk({31'h0, err}, 32'h0000_0001);
		wr(ca(0, CAL_FLD_UNLATCH), 32'h0000_0007);
		rdchk(ca(0, CAL_FLD_UNLATCH), 32'h0000_0000);
	endtask

	// 4..20 onto 0..100 with extrapolation, then the offset
	task automatic t_scale;
		logic [31:0] raw [5] = '{32'h0004_0000, 32'h000C_0000,
			32'h0014_0000, 32'h0000_0000, 32'h0017_0000};
		logic [31:0] exp [5] = '{32'h0000_0000, 32'h4248_0000,
			32'h42C8_0000, 32'hC1C8_0000, 32'h42ED_8000};
		wr(ca(0, CAL_FLD_LO_SIG), 32'h0004_0000);
		wr(ca(0, CAL_FLD_HI_SIG), 32'h0014_0000);
		wr(ca(0, CAL_FLD_HI_ENG), 32'h0064_0000);
		for (int i = 0; i < 5; i++) begin
			i_src.send(0, raw[i]);
			rdchk(ca(0, CAL_FLD_DATA), exp[i]);
		end
		wr(ca(0, CAL_FLD_OFFSET), 32'h0001_0000);
		i_src.send(0, 32'h000B_0000);
		rdchk(ca(0, CAL_FLD_DATA), 32'h4248_0000);
	endtask

	// latched versus plain low alarm, unlatch and interrupt
	task automatic t_latch;
		wr(ca(1, CAL_FLD_CTRL), 32'h0000_0001);
		wr(ca(1, CAL_FLD_LO_LIM), 32'h0000_0000);
		wr(ca(2, CAL_FLD_LO_LIM), 32'h0000_0000);
		wr(CAL_OFF_IRQ_MASK, 32'h0000_0002);
		i_src.send(1, 32'hFFFF_0000);
		chk(alm(1), 32'h0000_0001);
		chk({31'h0, irq_out}, 32'h0000_0001);
		i_src.send(2, 32'hFFFF_0000);
		i_src.send(1, 32'h0001_0000);
		chk(alm(1), 32'h0000_0001);
		i_src.send(2, 32'h0001_0000);
		chk(alm(2), 32'h0000_0000);
		rdchk(CAL_OFF_IRQ_STATUS, 32'h0000_0006);
		wr(CAL_OFF_IRQ_STATUS, 32'h0000_0002);
		chk({31'h0, irq_out}, 32'h0000_0000);
		rdchk(ca(1, CAL_FLD_ALARM), 32'h0000_0001);
		wr(ca(1, CAL_FLD_UNLATCH), 32'h0000_0001);
		chk(alm(1), 32'h0000_0000);
		i_src.send(1, 32'hFFFF_0000);
		chk(alm(1), 32'h0000_0001);
		wr(CAL_OFF_IRQ_STATUS, 32'h0000_0007);
		chk({31'h0, irq_out}, 32'h0000_0000);
	endtask

	// output channel: clamp high and rate alarms latched
	task automatic t_output;
		wr(ca(3, CAL_FLD_CTRL), 32'h0000_0003);
		wr(ca(3, CAL_FLD_HI_LIM), 32'h0002_0000);
		wr(ca(3, CAL_FLD_RATE), 32'h0001_0000);
		i_src.send(3, 32'h0000_8000);
		rdchk(ca(3, CAL_FLD_DATA), 32'h3F00_0000);
		i_src.send(3, 32'h0003_0000);
		chk(alm(3), 32'h0000_0006);
		rdchk(ca(3, CAL_FLD_DATA), 32'h4000_0000);
		i_src.send(3, 32'h0002_0000);
		chk(alm(3), 32'h0000_0006);
		wr(ca(3, CAL_FLD_UNLATCH), 32'h0000_0006);
		chk(alm(3), 32'h0000_0000);
	endtask

	// reset, then the scenarios in turn
	initial begin
		rst_in = 1'b1;
		psel_in = 1'b0;
		penable_in = 1'b0;
		pwrite_in = 1'b0;
		paddr_in = 12'h000;
		pwdata_in = 32'h0000_0000;
		repeat (16) @(posedge clk_in);
		rst_in <= 1'b0;
		@(negedge clk_in);
		t_regs();
		t_scale();
		t_latch();
		t_output();
		end_of_test();
	end
endmodule

bind cal_channel_core cal_channel_core_asserts #(.NCH(NCH)) i_asserts (
	.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel_in),
	.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
	.pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .raw_valid_in(raw_valid_in),
	.raw_chan_in(raw_chan_in), .raw_value_in(raw_value_in),
	.raw_ready_out(raw_ready_out), .alarm_out(alarm_out), .irq_out(irq_out));
